/* File: src/reset_seq_pkg.sv */
package reset_seq_pkg;

  // Clock rate of the low-speed oscillator that runs this block, in hertz.
  localparam int unsigned CLOCK_HZ = 20_000_000;

  // Reset delay after the supply first reaches its detection level, in microseconds.
  localparam int unsigned RESET_DELAY_US = 200;

  // Reset delay in clock cycles, with the clock rate truncated to whole megahertz; at least one cycle.
  localparam int unsigned RESET_DELAY_CYCLES = (RESET_DELAY_US * (CLOCK_HZ / 1_000_000) + 0) > 0 ?
                                               RESET_DELAY_US * (CLOCK_HZ / 1_000_000) : 1;

  // Power-up time-out lengths in oscillator cycles.
  localparam int unsigned TIMEOUT_AFTER_RESET = 36;
  localparam int unsigned TIMEOUT_AFTER_SLEEP = 10;

  // Cycle of the time-out at which the high-speed oscillator is enabled.
  localparam int unsigned OSC_ENABLE_CYCLE = 2;

  // Width of the time-out counter.
  localparam int unsigned TIMEOUT_WIDTH = 6;

  // Sequencer states, one-hot.
  typedef enum logic [4:0] {
    ST_RESET   = 5'b0_0001,
    ST_DELAY   = 5'b0_0010,
    ST_TIMEOUT = 5'b0_0100,
    ST_RUN     = 5'b0_1000,
    ST_SLEEP   = 5'b1_0000
  } seq_state_type;

endpackage

/* File: src/reset_sync.sv */
`timescale 1ns/1ps
`default_nettype none

// Two-stage synchroniser; the first stage is read by the second only.
module reset_sync (
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic d,
  output logic      q
);

  // First stage; the second stage is the output q.
  logic meta_q;

  // Both stages clear to a constant under the asynchronous reset.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_q <= 1'b0;
      q      <= 1'b0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule

`default_nettype wire

/* File: src/reset_power_up_sequencer.sv */
`timescale 1ns/1ps
`default_nettype none

module reset_power_up_sequencer #(
  parameter int unsigned DELAY_CYCLES = reset_seq_pkg::RESET_DELAY_CYCLES
) (
  input  wire logic CLOCK,
  input  wire logic RST_B,
  input  wire logic MASTER_CLEAR_PIN_B,
  input  wire logic SOFTWARE_RESET_REQUEST,
  input  wire logic WATCHDOG_RESET,
  input  wire logic SUPPLY_DETECT,
  input  wire logic SUPPLY_GOOD,
  input  wire logic SLEEP_REQUEST,
  input  wire logic EXTERNAL_WAKE_INTERRUPT,
  input  wire logic HOST_BUS_START,
  output logic      SYSTEM_RESET_OUT_B,
  output logic      HIGH_SPEED_OSC_ENABLE,
  output logic      PROCESSING_START,
  output logic      ANALOG_SUPPLY_ENABLE,
  output logic      CORE_SUPPLY_ENABLE
);

  // Counter width for the reset delay.
  localparam int unsigned DW = $clog2(DELAY_CYCLES + 1);

  // Combined asynchronous reset: any source pulls it low at once.
  wire any_reset_b;
  assign any_reset_b = RST_B & MASTER_CLEAR_PIN_B & ~SOFTWARE_RESET_REQUEST & ~WATCHDOG_RESET;

  // Synchronised pin inputs; the reset release is also synchronised this way.
  logic supply_detect_s;   // Supply has reached its detection level.
  logic supply_good_s;     // Supply has reached its operating level.
  logic wake_int_s;        // External wake interrupt.
  logic bus_start_s;       // Start condition seen on the host bus.
  logic reset_release_s;   // Reset release, synchronous to the clock.

  reset_sync u_rel (.clk(CLOCK), .rst_b(any_reset_b), .d(1'b1), .q(reset_release_s));
  reset_sync u_det (.clk(CLOCK), .rst_b(any_reset_b), .d(SUPPLY_DETECT), .q(supply_detect_s));
  reset_sync u_good (.clk(CLOCK), .rst_b(any_reset_b), .d(SUPPLY_GOOD), .q(supply_good_s));
  reset_sync u_wint (.clk(CLOCK), .rst_b(any_reset_b), .d(EXTERNAL_WAKE_INTERRUPT), .q(wake_int_s));
  reset_sync u_bus (.clk(CLOCK), .rst_b(any_reset_b), .d(HOST_BUS_START), .q(bus_start_s));

  // Sequencer state and counters.
  reset_seq_pkg::seq_state_type state_q, state_d;
  logic [DW-1:0]                              delay_q, delay_d;     // Reset delay counter.
  logic [reset_seq_pkg::TIMEOUT_WIDTH-1:0]    tmo_q, tmo_d;         // Time-out counter.
  logic [reset_seq_pkg::TIMEOUT_WIDTH-1:0]    tmo_len_q, tmo_len_d; // Active time-out length.
  logic                                       good_q, good_d;       // Supply good seen during time-out.

  // Decoded conditions.
  wire delay_done;
  wire tmo_done;
  wire wake_event;
  assign delay_done = (delay_q == DW'(DELAY_CYCLES - 1));
  assign tmo_done   = (tmo_q == tmo_len_q - 1'b1);
  assign wake_event = wake_int_s | bus_start_s;

  // Next-state logic of the sequencer.
  always_comb begin
    state_d   = state_q;
    delay_d   = delay_q;
    tmo_d     = tmo_q;
    tmo_len_d = tmo_len_q;
    good_d    = good_q;
    case (state_q)
      // Wait for synchronised release and supply detection.
      reset_seq_pkg::ST_RESET: begin
        if (reset_release_s && supply_detect_s) begin
          state_d = reset_seq_pkg::ST_DELAY;
          delay_d = '0;
        end
      end
      // Count the reset delay with system reset held low.
      reset_seq_pkg::ST_DELAY: begin
        if (delay_done) begin
          state_d   = reset_seq_pkg::ST_TIMEOUT;
          tmo_d     = '0;
          tmo_len_d = reset_seq_pkg::TIMEOUT_WIDTH'(reset_seq_pkg::TIMEOUT_AFTER_RESET);
          good_d    = 1'b0;
        end else begin
          delay_d = delay_q + 1'b1;
        end
      end
      // Count the time-out; supply must be good before its end.
      reset_seq_pkg::ST_TIMEOUT: begin
        if (supply_good_s) begin
          good_d = 1'b1;
        end
        if (tmo_done) begin
          if (good_q) begin
            state_d = reset_seq_pkg::ST_RUN;
          end else begin
            tmo_d = '0;                                                      // Retry until supply good.
          end
        end else begin
          tmo_d = tmo_q + 1'b1;
        end
      end
      // Processing; a sleep request enters deep sleep.
      reset_seq_pkg::ST_RUN: begin
        if (SLEEP_REQUEST) begin
          state_d = reset_seq_pkg::ST_SLEEP;
        end
      end
      // Deep sleep until a wake event; then the short time-out.
      reset_seq_pkg::ST_SLEEP: begin
        if (wake_event) begin
          state_d   = reset_seq_pkg::ST_TIMEOUT;
          tmo_d     = '0;
          tmo_len_d = reset_seq_pkg::TIMEOUT_WIDTH'(reset_seq_pkg::TIMEOUT_AFTER_SLEEP);
          good_d    = 1'b0;
        end
      end
      default: begin
        state_d = reset_seq_pkg::ST_RESET;
      end
    endcase
  end

  // State registers, cleared at once by any reset source.
  always_ff @(posedge CLOCK or negedge any_reset_b) begin
    if (!any_reset_b) begin
      state_q   <= reset_seq_pkg::ST_RESET;
      delay_q   <= '0;
      tmo_q     <= '0;
      tmo_len_q <= reset_seq_pkg::TIMEOUT_WIDTH'(reset_seq_pkg::TIMEOUT_AFTER_RESET);
      good_q    <= 1'b0;
    end else begin
      state_q   <= state_d;
      delay_q   <= delay_d;
      tmo_q     <= tmo_d;
      tmo_len_q <= tmo_len_d;
      good_q    <= good_d;
    end
  end

  // Registered outputs.
  always_ff @(posedge CLOCK or negedge any_reset_b) begin
    if (!any_reset_b) begin
      SYSTEM_RESET_OUT_B    <= 1'b0;
      HIGH_SPEED_OSC_ENABLE <= 1'b0;
      PROCESSING_START      <= 1'b0;
      ANALOG_SUPPLY_ENABLE  <= 1'b1;
      CORE_SUPPLY_ENABLE    <= 1'b1;
    end else begin
      SYSTEM_RESET_OUT_B    <= (state_d != reset_seq_pkg::ST_RESET) && (state_d != reset_seq_pkg::ST_DELAY);
      HIGH_SPEED_OSC_ENABLE <= (state_d == reset_seq_pkg::ST_RUN) ||
                               ((state_d == reset_seq_pkg::ST_TIMEOUT) &&
                                (tmo_d >= reset_seq_pkg::TIMEOUT_WIDTH'(reset_seq_pkg::OSC_ENABLE_CYCLE)));
      PROCESSING_START      <= (state_d == reset_seq_pkg::ST_RUN);
      ANALOG_SUPPLY_ENABLE  <= (state_d != reset_seq_pkg::ST_SLEEP);
      CORE_SUPPLY_ENABLE    <= 1'b1;
    end
  end

  // Helper counter of cycles spent in the time-out state.
  logic [7:0] tmo_cycles_q;
  always_ff @(posedge CLOCK or negedge any_reset_b) begin
    if (!any_reset_b) begin
      tmo_cycles_q <= '0;
    end else if (state_q == reset_seq_pkg::ST_TIMEOUT) begin
      tmo_cycles_q <= tmo_cycles_q + 8'h01;
    end else begin
      tmo_cycles_q <= '0;
    end
  end

  // Checks of the sequencer; all of them are switched off while any reset source is active.
  reset_out_low_a: assert property (@(posedge CLOCK) disable iff (!any_reset_b)
    (state_q == reset_seq_pkg::ST_DELAY) |-> !SYSTEM_RESET_OUT_B)
    else $error("System reset released during the reset delay.");

  release_after_delay_a: assert property (@(posedge CLOCK) disable iff (!any_reset_b)
    (state_q == reset_seq_pkg::ST_DELAY && delay_done) |=> SYSTEM_RESET_OUT_B && state_q == reset_seq_pkg::ST_TIMEOUT)
    else $error("Reset not released when the delay ended.");

  start_needs_timeout_a: assert property (@(posedge CLOCK) disable iff (!any_reset_b)
    $rose(PROCESSING_START) && tmo_len_q == reset_seq_pkg::TIMEOUT_WIDTH'(reset_seq_pkg::TIMEOUT_AFTER_RESET) |->
      tmo_cycles_q >= 8'(reset_seq_pkg::TIMEOUT_AFTER_RESET))
    else $error("Processing started before the long time-out.");

  short_timeout_a: assert property (@(posedge CLOCK) disable iff (!any_reset_b)
    $rose(PROCESSING_START) && tmo_len_q == reset_seq_pkg::TIMEOUT_WIDTH'(reset_seq_pkg::TIMEOUT_AFTER_SLEEP) |->
      tmo_cycles_q >= 8'(reset_seq_pkg::TIMEOUT_AFTER_SLEEP))
    else $error("Processing started before the short time-out.");

  start_needs_good_a: assert property (@(posedge CLOCK) disable iff (!any_reset_b)
    $rose(PROCESSING_START) |-> $past(good_q))
    else $error("Processing started without a good supply.");

  // The oscillator enable follows the time-out count: off before its cycle, on from it onwards.
  osc_enable_timing_a: assert property (@(posedge CLOCK) disable iff (!any_reset_b)
    (state_q == reset_seq_pkg::ST_TIMEOUT) |->
      (HIGH_SPEED_OSC_ENABLE == (tmo_q >= reset_seq_pkg::TIMEOUT_WIDTH'(reset_seq_pkg::OSC_ENABLE_CYCLE))))
    else $error("Oscillator enable off its time-out cycle.");

  analog_off_sleep_a: assert property (@(posedge CLOCK) disable iff (!any_reset_b)
    (state_q == reset_seq_pkg::ST_SLEEP) |-> !ANALOG_SUPPLY_ENABLE)
    else $error("Analog regulator on in deep sleep.");

  core_always_on_a: assert property (@(posedge CLOCK) disable iff (!any_reset_b)
    CORE_SUPPLY_ENABLE)
    else $error("Core regulator turned off.");

  wake_leaves_sleep_a: assert property (@(posedge CLOCK) disable iff (!any_reset_b)
    (state_q == reset_seq_pkg::ST_SLEEP && wake_event) |=> state_q == reset_seq_pkg::ST_TIMEOUT ##1 ANALOG_SUPPLY_ENABLE)
    else $error("Wake event did not leave deep sleep.");

endmodule

`default_nettype wire

/* File: test/board_supply_model.sv */
`timescale 1ns/1ps
`default_nettype none

// Board supply and external clear circuit. A slow ramp keeps the clear pin low until the supply is good.
module board_supply_model (
  input  wire logic clk,
  input  wire logic power_on,
  input  wire logic slow_ramp,
  input  wire logic clear_req,
  output logic      supply_detect,
  output logic      supply_good,
  output logic      master_clear_pin_b
);
  logic [7:0] ramp_q; // Cycles since power was applied.

  // Saturating ramp counter, cleared while power is off.
  always_ff @(posedge clk) begin
    if (!power_on) ramp_q <= 8'h00;
    else if (ramp_q != 8'hff) ramp_q <= ramp_q + 8'h01;
  end

  // A slow ramp reaches the operating level much later than a fast one.
  assign supply_detect      = power_on && (ramp_q >= 8'h02);
  assign supply_good        = power_on && (ramp_q >= (slow_ramp ? 8'h3c : 8'h05));
  assign master_clear_pin_b = !clear_req && !(slow_ramp && !supply_good);
endmodule

`default_nettype wire

/* File: test/reset_power_up_sequencer_tb.sv */
`timescale 1ns/1ps
`default_nettype none

// Self-checking bench: power-up, every reset source, sleep and wake, slow supply ramp.
module reset_power_up_sequencer_tb;
  localparam int DLY = 8; // Shortened reset delay.
  logic CLOCK = 1'b0, RST_B = 1'b0, SOFTWARE_RESET_REQUEST = 1'b0, WATCHDOG_RESET = 1'b0;
  logic SLEEP_REQUEST = 1'b0, EXTERNAL_WAKE_INTERRUPT = 1'b0, HOST_BUS_START = 1'b0;
  logic power_on = 1'b0, slow_ramp = 1'b0, clear_req = 1'b0;
  wire logic MASTER_CLEAR_PIN_B, SUPPLY_DETECT, SUPPLY_GOOD, SYSTEM_RESET_OUT_B, HIGH_SPEED_OSC_ENABLE;
  wire logic PROCESSING_START, ANALOG_SUPPLY_ENABLE, CORE_SUPPLY_ENABLE;
  wire logic [3:0] outs; // Outputs that the wait task watches, by index.
  int num_errors = 0, num_checks = 0;
  assign outs = {ANALOG_SUPPLY_ENABLE, HIGH_SPEED_OSC_ENABLE, PROCESSING_START, SYSTEM_RESET_OUT_B};

  // Clock of 50 ns period.
  always #25 CLOCK = ~CLOCK;

  board_supply_model board_supply_model_inst (.clk(CLOCK), .power_on(power_on), .slow_ramp(slow_ramp),
    .clear_req(clear_req), .supply_detect(SUPPLY_DETECT), .supply_good(SUPPLY_GOOD),
    .master_clear_pin_b(MASTER_CLEAR_PIN_B));

  reset_power_up_sequencer #(.DELAY_CYCLES(DLY)) reset_power_up_sequencer_inst (.CLOCK(CLOCK),
    .RST_B(RST_B), .MASTER_CLEAR_PIN_B(MASTER_CLEAR_PIN_B), .SOFTWARE_RESET_REQUEST(SOFTWARE_RESET_REQUEST),
    .WATCHDOG_RESET(WATCHDOG_RESET), .SUPPLY_DETECT(SUPPLY_DETECT), .SUPPLY_GOOD(SUPPLY_GOOD),
    .SLEEP_REQUEST(SLEEP_REQUEST), .EXTERNAL_WAKE_INTERRUPT(EXTERNAL_WAKE_INTERRUPT),
    .HOST_BUS_START(HOST_BUS_START), .SYSTEM_RESET_OUT_B(SYSTEM_RESET_OUT_B),
    .HIGH_SPEED_OSC_ENABLE(HIGH_SPEED_OSC_ENABLE), .PROCESSING_START(PROCESSING_START),
    .ANALOG_SUPPLY_ENABLE(ANALOG_SUPPLY_ENABLE), .CORE_SUPPLY_ENABLE(CORE_SUPPLY_ENABLE));

  // Compares one bit and counts the comparison.
  task automatic check(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Checks that a cycle count lies in a window.
  task automatic in_range(input int n, input int lo, input int hi);
    check(n >= lo && n <= hi, 1'b1);
  endtask

  // Waits, bounded, until an output reaches a level; n is the number of edges taken.
  task automatic wait_out(input int idx, input logic val, output int n);
    n = 0;
    while (outs[idx] !== val && n < 200) begin
      @(posedge CLOCK);
      #1;
      n++;
    end
  endtask

  // Power cycle, then timing of reset release, oscillator enable and start.
  task automatic power_up_test(input logic slow);
    int n;
    int m;
    @(posedge CLOCK);
    power_on <= 1'b0;
    RST_B <= 1'b0;
    slow_ramp <= slow;
    repeat (4) @(posedge CLOCK);
    power_on <= 1'b1;
    RST_B <= 1'b1;
    #1 wait_out(0, 1'b1, n);
    in_range(n, slow ? 60 : DLY, slow ? 60 + DLY + 12 : DLY + 6);
    check(PROCESSING_START, 1'b0);
    wait_out(2, 1'b1, m);
    in_range(m, 1, 3);
    wait_out(1, 1'b1, n);
    in_range(m + n, 36, 40);
    check(ANALOG_SUPPLY_ENABLE, 1'b1);
    check(CORE_SUPPLY_ENABLE, 1'b1);
    $display("power up test done");
  endtask

  // Master clear, software request and watchdog each drop the system reset at once; release waits for the clock.
  task automatic source_test();
    int n;
    for (int i = 0; i < 3; i++) begin
      @(posedge CLOCK);
      clear_req <= (i == 0);
      SOFTWARE_RESET_REQUEST <= (i == 1);
      WATCHDOG_RESET <= (i == 2);
      #1 check(SYSTEM_RESET_OUT_B, 1'b0);
      check(PROCESSING_START, 1'b0);
      @(posedge CLOCK);
      clear_req <= 1'b0;
      SOFTWARE_RESET_REQUEST <= 1'b0;
      WATCHDOG_RESET <= 1'b0;
      @(posedge CLOCK);
      #1 check(SYSTEM_RESET_OUT_B, 1'b0);
      wait_out(1, 1'b1, n);
      in_range(n, 36 + DLY, 36 + DLY + 10);
    end
    $display("source test done");
  endtask

  // Deep sleep, then wake by interrupt, by host start and by master clear.
  task automatic sleep_test();
    int n;
    for (int i = 0; i < 3; i++) begin
      @(posedge CLOCK);
      SLEEP_REQUEST <= 1'b1;
      @(posedge CLOCK);
      SLEEP_REQUEST <= 1'b0;
      #1 wait_out(3, 1'b0, n);
      check(n < 4, 1'b1);
      check(CORE_SUPPLY_ENABLE, 1'b1);
      check(PROCESSING_START, 1'b0);
      @(posedge CLOCK);
      EXTERNAL_WAKE_INTERRUPT <= (i == 0);
      HOST_BUS_START <= (i == 1);
      clear_req <= (i == 2);
      @(posedge CLOCK);
      EXTERNAL_WAKE_INTERRUPT <= 1'b0;
      HOST_BUS_START <= 1'b0;
      clear_req <= 1'b0;
      #1 wait_out(1, 1'b1, n);
      in_range(n, i == 2 ? 36 + DLY : 10, i == 2 ? 36 + DLY + 10 : 16);
      check(ANALOG_SUPPLY_ENABLE, 1'b1);
    end
    $display("sleep test done");
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // Main sequence.
  initial begin
    power_up_test(1'b0);
    source_test();
    sleep_test();
    power_up_test(1'b1);
    results();
  end

  // Watchdog against a hang.
  initial begin
    #(50 * 2000);
    num_errors++;
    results();
  end
endmodule

`default_nettype wire
